// ---- rtl/trig_sync_pkg.sv ----
// Summary of operation
// - Ready output goes high when armed for a trigger, just before exposure.
// - Status output is taken from one software-chosen timing source.
// - Optional inversion is applied to the status output after source selection.
// - Auxiliary output pulses a programmed delay after the trigger instant.
// - Gate monitor output is high for each whole intensifier gate.
// - Trigger-received output goes high at the trigger instant.
// - Rising early-trigger edge requests the end of continuous cleaning.
// - Cleaning stops only at the end of the cycle in progress.
// - Primary frequency output runs continuously, active high, until software halts it.
// - Lockout output is low while the intensifier is locked off.
// - Secondary frequency output lags the primary by 100 ns to 6.55 ms.
// - External trigger starts timing on a software-selected edge polarity.
package trig_sync_pkg;

  localparam longint CLK_MHZ = 200;

  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_AUX_DELAY = 8'h04;
  localparam logic [7:0] OFS_GATE_WIDTH = 8'h08;
  localparam logic [7:0] OFS_FREQ_PERIOD = 8'h0C;
  localparam logic [7:0] OFS_FREQ_HIGH = 8'h10;
  localparam logic [7:0] OFS_SYNC2_DELAY = 8'h14;
  localparam logic [7:0] OFS_STATUS = 8'h18;

  // ----------------------------------------
  // Field positions and reset values
  // ----------------------------------------
  localparam int CTRL_EXT_EN = 0;
  localparam int CTRL_EDGE_FALL = 1;
  localparam int CTRL_INVERT = 2;
  localparam int CTRL_FREQ_RUN = 3;
  localparam int CTRL_SEL_LSB = 4;
  localparam int CTRL_SW_TRIG = 8;
  localparam logic [31:0] CTRL_WR_MASK = 32'h0000007F;
  localparam int STS_READY = 0;
  localparam int STS_GATE = 1;
  localparam int STS_AUX_BUSY = 2;
  localparam int STS_CLEAN_PEND = 3;
  localparam int STS_LOCKOUT = 4;
  localparam int STS_FREQ1 = 5;
  localparam int STS_FREQ2 = 6;
  localparam int STS_ACQ = 7;
  localparam logic [31:0] CTRL_RST = 32'h00000000;
  localparam logic [31:0] AUX_DELAY_RST = 32'h00000014;
  localparam logic [31:0] GATE_WIDTH_RST = 32'h00000014;
  localparam logic [31:0] FREQ_PERIOD_RST = 32'h000000C8;
  localparam logic [31:0] FREQ_HIGH_RST = 32'h00000064;
  localparam logic [31:0] SYNC2_DELAY_RST = 32'h00000014;

  // Status output sources
  localparam logic [2:0] SEL_ACQ = 3'h0;
  localparam logic [2:0] SEL_SHIFT = 3'h1;
  localparam logic [2:0] SEL_ONE = 3'h2;
  localparam logic [2:0] SEL_READOUT = 3'h3;
  localparam logic [2:0] SEL_SHUTTER = 3'h4;
  localparam logic [2:0] SEL_WAIT = 3'h5;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_ARMED = 3'b010,
    ST_GATE = 3'b100
  } trig_state_e;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  function automatic logic [31:0] cyc_min(input longint ps);
    longint c;
    c = (ps * CLK_MHZ + 64'd999999) / 64'd1000000;
    return 32'((c < 1) ? 1 : c);
  endfunction

  function automatic logic [31:0] cyc_max(input longint ps);
    longint c;
    c = (ps * CLK_MHZ) / 64'd1000000;
    return 32'((c < 1) ? 1 : c);
  endfunction

  function automatic logic [31:0] clamp32(input logic [31:0] v, input logic [31:0] lo, input logic [31:0] hi);
    return (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  function automatic logic [31:0] dec32(input logic [31:0] v);
    return (v == 32'h0) ? 32'h0 : v - 32'h1;
  endfunction

  localparam longint AUX_DELAY_MIN_PS = 10;
  localparam longint AUX_DELAY_MAX_NS = 1000000000;
  localparam longint SYNC2_DELAY_MIN_NS = 100;
  localparam longint SYNC2_DELAY_MAX_NS = 6550000;
  localparam longint OUT_PULSE_NS = 100;
  localparam logic [31:0] AUX_DELAY_MIN_CYC = cyc_min(AUX_DELAY_MIN_PS);
  localparam logic [31:0] AUX_DELAY_MAX_CYC = cyc_max(AUX_DELAY_MAX_NS * 1000);
  localparam logic [31:0] SYNC2_DELAY_MIN_CYC = cyc_min(SYNC2_DELAY_MIN_NS * 1000);
  localparam logic [31:0] SYNC2_DELAY_MAX_CYC = cyc_max(SYNC2_DELAY_MAX_NS * 1000);
  localparam logic [31:0] OUT_PULSE_CYC = cyc_min(OUT_PULSE_NS * 1000);
  localparam logic [31:0] GATE_MIN_CYC = 32'h00000001;
  localparam logic [31:0] FREQ_MIN_PERIOD = 32'h00000002;

endpackage

// ---- rtl/period_gen_if.sv ----
`timescale 1ns/1ps
interface period_gen_if;
  logic ce;
  logic run;
  logic [31:0] period;
  logic [31:0] high;
  logic [31:0] delay2;
  logic out1;
  logic out2;
  modport ctrl (output ce, run, period, high, delay2, input out1, out2);
  modport gen (input ce, run, period, high, delay2, output out1, out2);
endinterface

// ---- rtl/freq_gen.sv ----
`timescale 1ns/1ps
module freq_gen
  import trig_sync_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Settings and outputs
  period_gen_if.gen pg
);

  logic act1, act2, dly_run;
  logic [31:0] cnt1, cnt2, per1, hi1, per2, hi2, dcnt;
  logic [31:0] lag, d_q;

  wire wrap1 = act1 && (cnt1 == per1 - 32'h1);
  wire wrap2 = act2 && (cnt2 == per2 - 32'h1);
  wire start = pg.run && !act1 && !act2 && !dly_run;
  wire start2 = dly_run && (dcnt == 32'h1);

  // ----------------------------------------
  // Primary: reload only on start or a wrap
  // ----------------------------------------
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      act1 <= 1'b0;
      cnt1 <= 32'h0;
      per1 <= FREQ_PERIOD_RST;
      hi1 <= FREQ_HIGH_RST;
    end else if (pg.ce) begin
      if (start || wrap1) begin
        act1 <= pg.run;
        cnt1 <= 32'h0;
        per1 <= pg.period;
        hi1 <= pg.high;
      end else if (act1) begin
        cnt1 <= cnt1 + 32'h1;
      end
    end
  end

  // ----------------------------------------
  // Secondary: delayed copy
  // ----------------------------------------
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      dly_run <= 1'b0;
      dcnt <= 32'h0;
      act2 <= 1'b0;
      cnt2 <= 32'h0;
      per2 <= FREQ_PERIOD_RST;
      hi2 <= FREQ_HIGH_RST;
    end else if (pg.ce) begin
      if (start) begin
        dly_run <= 1'b1;
        dcnt <= pg.delay2;
      end else if (dly_run) begin
        dly_run <= !start2;
        dcnt <= dec32(dcnt);
      end
      if (start2 || wrap2) begin
        act2 <= start2 || act1;
        cnt2 <= 32'h0;
        per2 <= per1;
        hi2 <= hi1;
      end else if (act2) begin
        cnt2 <= cnt2 + 32'h1;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pg.out1 <= 1'b0;
      pg.out2 <= 1'b0;
    end else if (pg.ce) begin
      pg.out1 <= act1 && (cnt1 < hi1);
      pg.out2 <= act2 && (cnt2 < hi2);
    end
  end

  // Lag measured for checking only
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      lag <= 32'h0;
      d_q <= 32'h0;
    end else if (pg.ce) begin
      lag <= start ? 32'h1 : lag + 32'h1;
      d_q <= start ? pg.delay2 : d_q;
    end
  end

  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n || !pg.ce);

  property p_sec_lag;
    start2 |-> lag == d_q;
  endproperty
  a_sec_lag: assert property (p_sec_lag) else $error("secondary lag wrong");

  property p_run_hold;
    act1 && !wrap1 |=> act1;
  endproperty
  a_run_hold: assert property (p_run_hold) else $error("primary stopped mid period");

  property p_reload;
    act1 && !wrap1 |=> $stable(per1) && $stable(hi1);
  endproperty
  a_reload: assert property (p_reload) else $error("settings changed mid period");

endmodule

// ---- rtl/camera_trigger_sync_io.sv ----
`timescale 1ns/1ps
module camera_trigger_sync_io
  import trig_sync_pkg::*;
#(
  parameter logic [31:0] AUX_DELAY_MAX = AUX_DELAY_MAX_CYC,
  parameter logic [31:0] SYNC2_DELAY_MAX = SYNC2_DELAY_MAX_CYC
) (
  // Clock, reset, enable
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic ce,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Timing generator status
  input wire logic acq_active,
  input wire logic image_shift,
  input wire logic readout_active,
  input wire logic shutter_open,
  input wire logic cleaning,
  input wire logic clean_cycle_end,
  input wire logic ii_locked_off,
  // Timing generator commands
  output logic trigger_instant,
  output logic clean_stop,
  // Trigger pins
  input wire logic ext_trig_in,
  input wire logic early_clean_stop_in,
  // Status pins
  output logic ready_out,
  output logic status_out,
  output logic aux_delay_out,
  output logic gate_monitor_out,
  output logic trigger_received_out,
  output logic lockout_out,
  output logic freq_out_primary,
  output logic freq_out_secondary
);

  // ----------------------------------------
  // Register file
  // ----------------------------------------
  logic [31:0] ctrl;
  logic [31:0] aux_delay;
  logic [31:0] gate_width;
  logic [31:0] freq_period;
  logic [31:0] freq_high;
  logic [31:0] sync2_delay;
  logic sw_trig;
  logic [31:0] rd_mux;
  logic [31:0] status_word;

  wire wr_ctrl = reg_wr && (reg_addr == OFS_CTRL);
  wire wr_aux = reg_wr && (reg_addr == OFS_AUX_DELAY);
  wire wr_gate = reg_wr && (reg_addr == OFS_GATE_WIDTH);
  wire wr_per = reg_wr && (reg_addr == OFS_FREQ_PERIOD);
  wire wr_high = reg_wr && (reg_addr == OFS_FREQ_HIGH);
  wire wr_sync2 = reg_wr && (reg_addr == OFS_SYNC2_DELAY);

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= CTRL_RST;
      aux_delay <= AUX_DELAY_RST;
      gate_width <= GATE_WIDTH_RST;
    end else if (ce) begin
      if (wr_ctrl) begin
        ctrl <= reg_wdata & CTRL_WR_MASK;
      end
      if (wr_aux) begin
        aux_delay <= reg_wdata;
      end
      if (wr_gate) begin
        gate_width <= reg_wdata;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      freq_period <= FREQ_PERIOD_RST;
      freq_high <= FREQ_HIGH_RST;
      sync2_delay <= SYNC2_DELAY_RST;
    end else if (ce) begin
      if (wr_per) begin
        freq_period <= reg_wdata;
      end
      if (wr_high) begin
        freq_high <= reg_wdata;
      end
      if (wr_sync2) begin
        sync2_delay <= reg_wdata;
      end
    end
  end

  // Software trigger is a one-cycle pulse, never stored
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sw_trig <= 1'b0;
    end else if (ce) begin
      sw_trig <= wr_ctrl && reg_wdata[CTRL_SW_TRIG];
    end
  end

  always_comb begin
    case (reg_addr)
      OFS_CTRL: rd_mux = ctrl;
      OFS_AUX_DELAY: rd_mux = aux_delay;
      OFS_GATE_WIDTH: rd_mux = gate_width;
      OFS_FREQ_PERIOD: rd_mux = freq_period;
      OFS_FREQ_HIGH: rd_mux = freq_high;
      OFS_SYNC2_DELAY: rd_mux = sync2_delay;
      OFS_STATUS: rd_mux = status_word;
      default: rd_mux = 32'h0;
    endcase
  end

  // Data only in the cycle after the strobe
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 32'h0;
    end else if (ce) begin
      reg_rdata <= reg_rd ? rd_mux : 32'h0;
    end
  end

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic trig_s1, trig_s2, trig_s3;
  logic pre_s1, pre_s2, pre_s3;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      trig_s1 <= 1'b0;
      trig_s2 <= 1'b0;
      trig_s3 <= 1'b0;
      pre_s1 <= 1'b0;
      pre_s2 <= 1'b0;
      pre_s3 <= 1'b0;
    end else if (ce) begin
      trig_s1 <= ext_trig_in;
      trig_s2 <= trig_s1;
      trig_s3 <= trig_s2;
      pre_s1 <= early_clean_stop_in;
      pre_s2 <= pre_s1;
      pre_s3 <= pre_s2;
    end
  end

  // XOR with polarity makes both edges one detector
  wire trig_now = trig_s2 ^ ctrl[CTRL_EDGE_FALL];
  wire trig_old = trig_s3 ^ ctrl[CTRL_EDGE_FALL];
  wire ext_edge = trig_now && !trig_old;
  wire pre_edge = pre_s2 && !pre_s3;

  // ----------------------------------------
  // Trigger state machine
  // ----------------------------------------
  trig_state_e st, next_st;
  logic [31:0] gate_cnt;

  wire ext_sel = ctrl[CTRL_EXT_EN];
  wire armed = (st == ST_ARMED);
  wire trig_hit = armed && (ext_sel ? ext_edge : sw_trig);
  wire gate_last = (st == ST_GATE) && (gate_cnt == 32'h1);
  wire [31:0] gate_eff = clamp32(gate_width, GATE_MIN_CYC, 32'hFFFFFFFF);
  wire [31:0] dly_eff = clamp32(aux_delay, AUX_DELAY_MIN_CYC, AUX_DELAY_MAX);

  always_comb begin
    next_st = st;
    case (st)
      ST_IDLE: begin
        if (acq_active && !cleaning) begin
          next_st = ST_ARMED;
        end
      end
      ST_ARMED: begin
        if (!acq_active) begin
          next_st = ST_IDLE;
        end else if (trig_hit) begin
          next_st = ST_GATE;
        end
      end
      ST_GATE: begin
        if (gate_last) begin
          next_st = ST_IDLE;
        end
      end
      default: next_st = ST_IDLE;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st <= ST_IDLE;
      gate_cnt <= 32'h0;
    end else if (ce) begin
      st <= next_st;
      gate_cnt <= trig_hit ? gate_eff : dec32(gate_cnt);
    end
  end

  // ----------------------------------------
  // Trigger-related outputs
  // ----------------------------------------
  logic [31:0] trx_cnt, dly_cnt, aux_cnt;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ready_out <= 1'b0;
      gate_monitor_out <= 1'b0;
      trigger_instant <= 1'b0;
    end else if (ce) begin
      ready_out <= (next_st == ST_ARMED);
      gate_monitor_out <= (next_st == ST_GATE);
      trigger_instant <= trig_hit;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      trigger_received_out <= 1'b0;
      trx_cnt <= 32'h0;
    end else if (ce) begin
      if (trig_hit) begin
        trigger_received_out <= 1'b1;
        trx_cnt <= OUT_PULSE_CYC;
      end else begin
        trigger_received_out <= (trx_cnt > 32'h1);
        trx_cnt <= dec32(trx_cnt);
      end
    end
  end

  // A new trigger restarts a delay still counting
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      dly_cnt <= 32'h0;
    end else if (ce) begin
      dly_cnt <= trig_hit ? dly_eff : dec32(dly_cnt);
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      aux_delay_out <= 1'b0;
      aux_cnt <= 32'h0;
    end else if (ce) begin
      if (dly_cnt == 32'h1) begin
        aux_delay_out <= 1'b1;
        aux_cnt <= OUT_PULSE_CYC;
      end else begin
        aux_delay_out <= (aux_cnt > 32'h1);
        aux_cnt <= dec32(aux_cnt);
      end
    end
  end

  // ----------------------------------------
  // Status and lockout
  // ----------------------------------------
  wire [2:0] sel = ctrl[CTRL_SEL_LSB +: 3];
  wire sel_src = (sel == SEL_ACQ) ? acq_active :
                 (sel == SEL_SHIFT) ? image_shift :
                 (sel == SEL_ONE) ? 1'b1 :
                 (sel == SEL_READOUT) ? readout_active :
                 (sel == SEL_SHUTTER) ? shutter_open :
                 (sel == SEL_WAIT) ? armed : 1'b0;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      status_out <= 1'b0;
      lockout_out <= 1'b0;
    end else if (ce) begin
      status_out <= sel_src ^ ctrl[CTRL_INVERT];
      lockout_out <= !ii_locked_off;
    end
  end

  // ----------------------------------------
  // Cleaning stop
  // ----------------------------------------
  logic clean_pend;
  // Edges outside acquisition are dropped
  wire clean_ev = (pre_edge || (ext_sel && ext_edge)) && acq_active && cleaning;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      clean_pend <= 1'b0;
      clean_stop <= 1'b0;
    end else if (ce) begin
      // New event wins over the cycle-end clear
      clean_pend <= clean_ev || (clean_pend && cleaning && !clean_cycle_end);
      clean_stop <= clean_pend && cleaning && clean_cycle_end;
    end
  end

  // ----------------------------------------
  // Frequency outputs
  // ----------------------------------------
  period_gen_if pg_if();

  assign pg_if.ce = ce;
  assign pg_if.run = ctrl[CTRL_FREQ_RUN];
  assign pg_if.period = clamp32(freq_period, FREQ_MIN_PERIOD, 32'hFFFFFFFF);
  assign pg_if.high = freq_high;
  assign pg_if.delay2 = clamp32(sync2_delay, SYNC2_DELAY_MIN_CYC, SYNC2_DELAY_MAX);
  assign freq_out_primary = pg_if.out1;
  assign freq_out_secondary = pg_if.out2;

  freq_gen u_freq_gen (
    .mclk(mclk),
    .rst_n(rst_n),
    .pg(pg_if.gen)
  );

  assign status_word = {24'h0, acq_active, freq_out_secondary, freq_out_primary, lockout_out,
                        clean_pend, (dly_cnt != 32'h0), gate_monitor_out, ready_out};

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  logic [31:0] since_trig, dly_q;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      since_trig <= 32'h0;
      dly_q <= 32'h0;
    end else if (ce) begin
      since_trig <= trig_hit ? 32'h0 : since_trig + 32'h1;
      dly_q <= trig_hit ? dly_eff : dly_q;
    end
  end

  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n || !ce);

  sequence s_trig;
    trig_hit;
  endsequence

  sequence s_pulse_start;
    $rose(trigger_received_out) ##0 trigger_received_out [*4];
  endsequence

  property p_ready_rise;
    $rose(ready_out) |-> $past(acq_active) && !$past(cleaning);
  endproperty
  a_ready_rise: assert property (p_ready_rise) else $error("ready without acquisition");

  property p_sel_one;
    (sel == SEL_ONE) && !ctrl[CTRL_INVERT] |=> status_out;
  endproperty
  a_sel_one: assert property (p_sel_one) else $error("constant source not high");

  property p_invert;
    (sel == SEL_ONE) && ctrl[CTRL_INVERT] |=> !status_out;
  endproperty
  a_invert: assert property (p_invert) else $error("inversion not applied");

  property p_aux_delay;
    $rose(aux_delay_out) |-> since_trig == dly_q;
  endproperty
  a_aux_delay: assert property (p_aux_delay) else $error("aux delay wrong");

  property p_gate;
    s_trig |=> gate_monitor_out ##0 (st == ST_GATE);
  endproperty
  a_gate: assert property (p_gate) else $error("gate monitor missing");

  // A retrigger inside a running pulse cannot show a rise
  property p_trx;
    s_trig ##0 !trigger_received_out |=> s_pulse_start;
  endproperty
  a_trx: assert property (p_trx) else $error("trigger received pulse wrong");

  property p_pretrig;
    pre_edge && acq_active && cleaning |=> clean_pend;
  endproperty
  a_pretrig: assert property (p_pretrig) else $error("early trigger lost");

  property p_clean_end;
    clean_pend && cleaning && !clean_cycle_end && !clean_ev |=> !clean_stop;
  endproperty
  a_clean_end: assert property (p_clean_end) else $error("cleaning cut mid cycle");

  property p_lockout;
    ii_locked_off |=> !lockout_out;
  endproperty
  a_lockout: assert property (p_lockout) else $error("lockout not low");

  property p_ext_edge;
    armed && acq_active && ext_sel && ext_edge |=> (st == ST_GATE);
  endproperty
  a_ext_edge: assert property (p_ext_edge) else $error("external edge not taken");

  property p_sync;
    pre_edge |-> $past(early_clean_stop_in, 2) && !$past(early_clean_stop_in, 3);
  endproperty
  a_sync: assert property (p_sync) else $error("early trigger not synchronised");

endmodule

// ---- dv/far_instruments.sv ----
`timescale 1ns/1ps
// ----------------------------------------
// External instruments on trigger pins
// ----------------------------------------
module far_instruments (
  // Pins toward camera
  output logic ext_trig_in,
  output logic early_clean_stop_in
);
  initial begin
    ext_trig_in = 1'b0;
    early_clean_stop_in = 1'b0;
  end
  // Off-grid edges; held 100 ns as a TTL source would
  task automatic set_trig(input logic lvl);
    #2.3 ext_trig_in = lvl;
    #100;
  endtask
  // Caller sends it only once src_acquisition_active, except to test refusal
  task automatic pre_pulse();
    #1.7 early_clean_stop_in = 1'b1;
    #100 early_clean_stop_in = 1'b0;
    #100;
  endtask
endmodule

// ---- dv/camera_trigger_sync_io_tb.sv ----
`timescale 1ns/1ps
module camera_trigger_sync_io_tb;
  import trig_sync_pkg::*;
  localparam logic [31:0] AUX_MAX = 32'h00000064;
  localparam logic [31:0] S2_MAX = 32'h0000003C;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h00000000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic acq_active = 1'b0, image_shift = 1'b0, readout_active = 1'b0, shutter_open = 1'b0;
  logic cleaning = 1'b0, clean_cycle_end = 1'b0, ii_locked_off = 1'b0;
  logic [31:0] reg_rdata;
  logic trigger_instant, clean_stop, ext_trig_in, early_clean_stop_in, ready_out, status_out;
  logic aux_delay_out, gate_monitor_out, trigger_received_out, lockout_out, freq_out_primary, freq_out_secondary;
  int failures = 0;
  int n_tests = 0;
  int n_trig = 0;
  int n_stop = 0;
  int first [5];
  int cnt [5];
  bit q [5][200];
  logic [31:0] rnd = 32'h5C282332;
  logic [31:0] mdl [7];

  always #2.5 mclk = ~mclk;

  camera_trigger_sync_io #(.AUX_DELAY_MAX(AUX_MAX), .SYNC2_DELAY_MAX(S2_MAX)) dut (
    .mclk(mclk), .rst_n(rst_n), .ce(1'b1), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .acq_active(acq_active), .image_shift(image_shift),
    .readout_active(readout_active), .shutter_open(shutter_open), .cleaning(cleaning),
    .clean_cycle_end(clean_cycle_end), .ii_locked_off(ii_locked_off), .trigger_instant(trigger_instant),
    .clean_stop(clean_stop), .ext_trig_in(ext_trig_in), .early_clean_stop_in(early_clean_stop_in),
    .ready_out(ready_out), .status_out(status_out), .aux_delay_out(aux_delay_out),
    .gate_monitor_out(gate_monitor_out), .trigger_received_out(trigger_received_out),
    .lockout_out(lockout_out), .freq_out_primary(freq_out_primary), .freq_out_secondary(freq_out_secondary));

  far_instruments inst (.ext_trig_in(ext_trig_in), .early_clean_stop_in(early_clean_stop_in));

  always @(posedge mclk) begin
    if (trigger_instant === 1'b1) n_trig++;
    if (clean_stop === 1'b1) n_stop++;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
    if (a < OFS_STATUS) mdl[a[4:2]] = (a == OFS_CTRL) ? (d & CTRL_WR_MASK) : d;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string name);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 chk(name, reg_rdata, exp);
  endtask

  // Rows: received, gate, aux, primary, secondary
  task automatic sample(input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge mclk);
      #1;
      q[0][i] = trigger_received_out;
      q[1][i] = gate_monitor_out;
      q[2][i] = aux_delay_out;
      q[3][i] = freq_out_primary;
      q[4][i] = freq_out_secondary;
      if (gate_monitor_out === 1'b1) chk("ready_in_gate", ready_out, 32'h0);
    end
    for (int r = 0; r < 5; r++) begin
      first[r] = -1;
      cnt[r] = 0;
      for (int i = 0; i < n; i++) begin
        if (q[r][i] && first[r] < 0) first[r] = i;
        if (q[r][i] && i < first[r] + 100) cnt[r]++;
      end
    end
  endtask

  task automatic wait_ready();
    for (int i = 0; i < 60 && ready_out !== 1'b1; i++) begin
      @(posedge mclk);
      #1;
    end
    chk("ready", ready_out, 32'h1);
  endtask

  task automatic cyc_end();
    @(posedge mclk);
    clean_cycle_end <= 1'b1;
    @(posedge mclk);
    clean_cycle_end <= 1'b0;
    repeat (3) @(posedge mclk);
  endtask

  task automatic end_sim();
    $display("checks %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    #150000;
    failures++;
    end_sim();
  end

  initial begin
    int s;
    static int dly [3] = '{5, 0, 200};
    static int gw [3] = '{7, 0, 3};
    logic [7:0] src;
    mdl = '{CTRL_RST, AUX_DELAY_RST, GATE_WIDTH_RST, FREQ_PERIOD_RST, FREQ_HIGH_RST, SYNC2_DELAY_RST, 32'h0};
    repeat (6) @(posedge mclk);
    rst_n <= 1'b1;
    for (int i = 0; i < 6; i++) rd(8'(4 * i), mdl[i], "reset_reg");
    rd(8'h1C, 32'h0, "unmapped");
    wr(OFS_STATUS, 32'hFFFFFFFF);
    rd(OFS_STATUS, 32'h10, "status_reg");
    wr(OFS_CTRL, 32'hFFFFFF77);
    rd(OFS_CTRL, mdl[0], "ctrl_mask");
    // Cleaning held high so the waiting source stays low
    cleaning <= 1'b1;
    for (int i = 0; i < 16; i++) begin
      rnd = lfsr(rnd);
      {ii_locked_off, acq_active, shutter_open, readout_active, image_shift} <= rnd[4:0];
      wr(OFS_CTRL, 32'((i % 8) << 4 | (i / 8) << 2));
      repeat (2) @(posedge mclk);
      #1;
      src = {3'b000, shutter_open, readout_active, 1'b1, image_shift, acq_active};
      chk("status_out", status_out, 32'(src[i % 8] ^ (i / 8)));
      chk("lockout_out", lockout_out, 32'(!ii_locked_off));
    end
    acq_active <= 1'b1;
    cleaning <= 1'b0;
    wr(OFS_CTRL, 32'h50);
    wait_ready();
    @(posedge mclk);
    #1;
    chk("status_wait", status_out, 32'h1);
    for (int k = 0; k < 3; k++) begin
      wr(OFS_AUX_DELAY, 32'(dly[k]));
      wr(OFS_GATE_WIDTH, 32'(gw[k]));
      wait_ready();
      s = n_trig;
      wr(OFS_CTRL, 32'h100);
      sample(140);
      chk("recv_first", 32'(first[0]), 32'h0);
      chk("recv_len", 32'(cnt[0]), 32'd20);
      chk("gate_first", 32'(first[1]), 32'h0);
      chk("gate_len", 32'(cnt[1]), 32'((gw[k] < 1) ? 1 : gw[k]));
      chk("aux_first", 32'(first[2]), 32'((dly[k] < 1) ? 1 : ((dly[k] > AUX_MAX) ? AUX_MAX : dly[k])));
      chk("aux_len", 32'(cnt[2]), 32'd20);
      chk("n_trig", 32'(n_trig - s), 32'h1);
    end
    for (int p = 0; p < 2; p++) begin
      wr(OFS_CTRL, 32'(1 + p * 2));
      wait_ready();
      s = n_trig;
      inst.set_trig(1'b1);
      repeat (5) @(posedge mclk);
      chk("ext_lead", 32'(n_trig - s), 32'(1 - p));
      inst.set_trig(1'b0);
      repeat (5) @(posedge mclk);
      chk("ext_trail", 32'(n_trig - s), 32'h1);
    end
    wr(OFS_CTRL, 32'h0);
    cleaning <= 1'b1;
    s = n_stop;
    inst.pre_pulse();
    chk("stop_early", 32'(n_stop - s), 32'h0);
    cyc_end();
    chk("stop_at_end", 32'(n_stop - s), 32'h1);
    acq_active <= 1'b0;
    inst.pre_pulse();
    cyc_end();
    chk("stop_idle", 32'(n_stop - s), 32'h1);
    wr(OFS_FREQ_PERIOD, 32'd10);
    wr(OFS_FREQ_HIGH, 32'd3);
    wr(OFS_SYNC2_DELAY, 32'd25);
    wr(OFS_CTRL, 32'h8);
    sample(200);
    chk("freq1_high", 32'(cnt[3]), 32'd30);
    chk("freq2_high", 32'(cnt[4]), 32'd30);
    chk("freq2_lag", 32'(first[4] - first[3]), 32'd25);
    wr(OFS_CTRL, 32'h0);
    repeat (30) @(posedge mclk);
    sample(40);
    chk("freq1_halt", 32'(first[3]), 32'hFFFFFFFF);
    chk("freq2_halt", 32'(first[4]), 32'hFFFFFFFF);
    end_sim();
  end
endmodule
